// [hdl/fan_cfg_pkg.sv]
// constants, offsets and types for the fan monitor config register slice
package fan_cfg_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CFG4 = 8'h7D;
	localparam logic [7:0] IDX_TEST1 = 8'h7E;
	localparam logic [7:0] IDX_TEST2 = 8'h7F;
	localparam logic [7:0] IDX_TEST3 = 8'h80;
	localparam logic [7:0] IDX_LOCK = 8'h81;
	localparam logic [7:0] IDX_STATUS = 8'h82;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned TEST_N = 3;

	// configuration register fields
	localparam int unsigned ROLE_LSB = 0;
	localparam int unsigned ROLE_MSB = 1;
	localparam int unsigned OT_OFF_BIT = 2;
	localparam int unsigned RESP_SEL_BIT = 3;
	localparam int unsigned CHAN_SEL_BIT = 4;
	localparam int unsigned BYPASS_BIT = 5;
	localparam logic [7:0] CFG4_WR_MASK = 8'h3F;
	localparam logic [7:0] CFG4_RST = 8'h00;

	// lock and status fields
	localparam int unsigned LOCK_BIT = 0;
	localparam int unsigned ST_OVERRIDE_BIT = 0;
	localparam int unsigned ST_ALARM_DRV_BIT = 1;
	localparam int unsigned ST_LOCK_BIT = 2;
	localparam int unsigned ST_PIN_SENSE_BIT = 3;

	// factory test register reset values
	localparam logic [7:0] TEST1_RST = 8'h00;
	localparam logic [7:0] TEST2_RST = 8'h00;
	localparam logic [7:0] TEST3_RST = 8'h10;

	// fan drive and supply scale
	localparam logic [7:0] FULL_DUTY = 8'hFF;
	localparam logic [21:0] SUPPLY_FS_BYPASS_UV = 22'h230AB4;

	typedef enum logic [1:0] {
		ROLE_FAN_TACH = 2'b00,
		ROLE_THERMAL_ALARM_PIN = 2'b01,
		ROLE_ALERT = 2'b10,
		ROLE_GPIO = 2'b11
	} pin_role_e;
endpackage

// [hdl/cfg_apb_front.sv]
// apb phase decode and word index extraction for the config slice
module cfg_apb_front
	import fan_cfg_pkg::*;
(
	// apb request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [3:0] pstrb,
	// decoded
	output logic setup,
	output logic access,
	output logic wr_stb,
	output logic addr_ok,
	output logic [7:0] index
);
	// zero wait states: every access phase completes at its first edge
	assign setup = psel & ~penable;
	assign access = psel & penable;
	// registers are one byte wide, so only lane 0 carries a write
	assign wr_stb = access & pwrite & pstrb[0];
	assign index = paddr[9:2];
	assign addr_ok = (paddr[1:0] == 2'b00) & (paddr[ADDR_W-1:10] == '0);
endmodule

// [hdl/fan_monitor_config_four_regs.sv]
// config register, lock, test registers and their fan/pin effects
module fan_monitor_config_four_regs
	import fan_cfg_pkg::*;
#(
	parameter bit HAS_CHAN_SEL = 1'b0,
	parameter logic [21:0] SUPPLY_FS_NORMAL_UV = 22'h2DC6C0
)
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// thermal monitor
	input wire logic thermal_limit_hit,
	// fan loop demand and per-fan maximum settings
	input wire logic [7:0] fan_demand_1,
	input wire logic [7:0] fan_demand_2,
	input wire logic [7:0] fan_demand_3,
	input wire logic [7:0] fan_max_speed_1,
	input wire logic [7:0] fan_max_speed_2,
	input wire logic [7:0] fan_max_speed_3,
	// fan drive
	output logic [7:0] fan_duty_1,
	output logic [7:0] fan_duty_2,
	output logic [7:0] fan_duty_3,
	output logic fan_override_active,
	// shared pin role enables
	output logic fan_four_speed_input_en,
	output logic thermal_alarm_role_en,
	output logic smbalert_role_en,
	output logic gpio_role_en,
	// shared pin as open-drain alarm
	input wire logic thermal_alarm_pin_i,
	output logic thermal_alarm_pin_o,
	output logic thermal_alarm_pin_oe,
	// thermal channel selection
	output logic thermal_alarm_pin_remote1_en,
	output logic thermal_alarm_pin_remote2_en,
	// processor supply channel scale
	output logic supply_attenuator_bypass,
	output logic [21:0] supply_fullscale_uv
);
	logic setup;
	logic access;
	logic wr_stb;
	logic addr_ok;
	logic [7:0] index;

	cfg_apb_front u_front (
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pstrb(pstrb),
		.setup(setup),
		.access(access),
		.wr_stb(wr_stb),
		.addr_ok(addr_ok),
		.index(index)
	);

	logic [7:0] cfg4_r;
	logic [7:0] cfg4_nxt;
	logic lock_r;
	logic [7:0] test_r [0:TEST_N-1];
	logic [31:0] prdata_r;
	logic alarm_oe_r;
	logic override_r;
	logic [7:0] duty_1_r;
	logic [7:0] duty_2_r;
	logic [7:0] duty_3_r;
	logic [1:0] pin_sense_r;

	// address decode
	function automatic logic is_test(input logic [7:0] idx);
		is_test = (idx >= IDX_TEST1) && (idx <= IDX_TEST3);
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx == IDX_CFG4) || is_test(idx) ||
			(idx == IDX_LOCK) || (idx == IDX_STATUS);
	endfunction

	// overtemp drive for one fan: full or programmed maximum
	function automatic logic [7:0] fan_pick(input logic hit,
		input logic use_max, input logic [7:0] demand,
		input logic [7:0] max_spd);
		if (!hit)
			fan_pick = demand;
		else if (use_max)
			fan_pick = max_spd;
		else
			fan_pick = FULL_DUTY;
	endfunction

	wire hit_map = addr_ok & is_mapped(index);
	wire wr_cfg = wr_stb & addr_ok & (index == IDX_CFG4);
	wire wr_lock = wr_stb & addr_ok & (index == IDX_LOCK);
	wire [1:0] test_sel = 2'(index - IDX_TEST1);

	// field views of the config register
	wire [1:0] role = cfg4_r[ROLE_MSB:ROLE_LSB];
	wire ot_off = cfg4_r[OT_OFF_BIT];
	wire resp_max = cfg4_r[RESP_SEL_BIT];
	wire chan_both = cfg4_r[CHAN_SEL_BIT];
	wire bypass = cfg4_r[BYPASS_BIT];

	wire role_tach = role == ROLE_FAN_TACH;
	wire role_thermal_alarm_pin = role == ROLE_THERMAL_ALARM_PIN;
	wire role_alert = role == ROLE_ALERT;
	wire role_gpio = role == ROLE_GPIO;

	// only the low six bits are storage; the top two stay zero
	// a locked register ignores the write without a bus error
	assign cfg4_nxt = (wr_cfg && !lock_r) ?
		(pwdata[7:0] & CFG4_WR_MASK) : cfg4_r;

	wire alarm_nxt = role_thermal_alarm_pin & ~ot_off & thermal_limit_hit;

	wire [31:0] status_word = {28'h0000000, pin_sense_r[1],
		lock_r, alarm_oe_r, override_r};

	wire [7:0] rd_byte =
		!hit_map ? 8'h00 :
		(index == IDX_CFG4) ? cfg4_r :
		(index == IDX_LOCK) ? {7'h00, lock_r} :
		(index == IDX_STATUS) ? status_word[7:0] :
		test_r[test_sel];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cfg4_r <= CFG4_RST;
		else
			cfg4_r <= cfg4_nxt;
	end

	// lock is sticky: only reset clears it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			lock_r <= 1'b0;
		else if (wr_lock && pwdata[LOCK_BIT])
			lock_r <= 1'b1;
	end

	// test registers hold their reset value; writes never reach them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			test_r[0] <= TEST1_RST;
			test_r[1] <= TEST2_RST;
			test_r[2] <= TEST3_RST;
		end
	end

	// read data captured in setup so it is ready for a zero-wait access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			prdata_r <= 32'h00000000;
		else if (setup && !pwrite)
			prdata_r <= {24'h000000, rd_byte};
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alarm_oe_r <= 1'b0;
			override_r <= 1'b0;
			pin_sense_r <= 2'b00;
		end else begin
			alarm_oe_r <= alarm_nxt;
			override_r <= thermal_limit_hit;
			pin_sense_r <= {pin_sense_r[0],
				role_thermal_alarm_pin & ~alarm_oe_r & ~thermal_alarm_pin_i};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			duty_1_r <= 8'h00;
			duty_2_r <= 8'h00;
			duty_3_r <= 8'h00;
		end else begin
			duty_1_r <= fan_pick(thermal_limit_hit, resp_max,
				fan_demand_1, fan_max_speed_1);
			duty_2_r <= fan_pick(thermal_limit_hit, resp_max,
				fan_demand_2, fan_max_speed_2);
			duty_3_r <= fan_pick(thermal_limit_hit, resp_max,
				fan_demand_3, fan_max_speed_3);
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = access & ~hit_map;

	assign fan_duty_1 = duty_1_r;
	assign fan_duty_2 = duty_2_r;
	assign fan_duty_3 = duty_3_r;
	assign fan_override_active = override_r;

	assign fan_four_speed_input_en = role_tach;
	assign thermal_alarm_role_en = role_thermal_alarm_pin;
	assign smbalert_role_en = role_alert;
	assign gpio_role_en = role_gpio;

	// open drain: only ever pulls low
	assign thermal_alarm_pin_o = 1'b0;
	assign thermal_alarm_pin_oe = alarm_oe_r;

	// base variant ignores the select and watches remote two only
	assign thermal_alarm_pin_remote2_en = 1'b1;
	assign thermal_alarm_pin_remote1_en = HAS_CHAN_SEL & chan_both;

	assign supply_attenuator_bypass = bypass;
	assign supply_fullscale_uv = bypass ? SUPPLY_FS_BYPASS_UV :
		SUPPLY_FS_NORMAL_UV;

	// checks
	logic first_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			first_r <= 1'b1;
		else
			first_r <= 1'b0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_locked_write;
		lock_r && wr_cfg;
	endsequence

	sequence s_open_write;
		!lock_r && wr_cfg;
	endsequence

	sequence s_read_test3;
		setup && !pwrite && addr_ok && (index == IDX_TEST3);
	endsequence

	sequence s_read_cfg;
		setup && !pwrite && addr_ok && (index == IDX_CFG4);
	endsequence

	property p_role_decode;
		(role == ROLE_THERMAL_ALARM_PIN) |-> thermal_alarm_role_en &&
			!fan_four_speed_input_en && !smbalert_role_en &&
			!gpio_role_en;
	endproperty
	a_role_decode: assert property (p_role_decode)
		else $error("shared pin role decode wrong");

	property p_alarm_off;
		ot_off |=> !thermal_alarm_pin_oe;
	endproperty
	a_alarm_off: assert property (p_alarm_off)
		else $error("alarm pin driven while overtemp output is off");

	property p_full_speed;
		(thermal_limit_hit && !resp_max) |=> (fan_duty_1 == FULL_DUTY)
			&& (fan_duty_2 == FULL_DUTY) && (fan_duty_3 == FULL_DUTY);
	endproperty
	a_full_speed: assert property (p_full_speed)
		else $error("fans not at full speed on overtemp");

	property p_max_speed;
		(thermal_limit_hit && resp_max) |=>
			(fan_duty_1 == $past(fan_max_speed_1)) &&
			(fan_duty_2 == $past(fan_max_speed_2)) &&
			(fan_duty_3 == $past(fan_max_speed_3));
	endproperty
	a_max_speed: assert property (p_max_speed)
		else $error("fans not at programmed maximum on overtemp");

	property p_chan_sel;
		(!HAS_CHAN_SEL || !chan_both) |-> thermal_alarm_pin_remote2_en &&
			!thermal_alarm_pin_remote1_en;
	endproperty
	a_chan_sel: assert property (p_chan_sel)
		else $error("remote one used without channel select");

	property p_bypass_scale;
		bypass |-> supply_fullscale_uv == SUPPLY_FS_BYPASS_UV;
	endproperty
	a_bypass_scale: assert property (p_bypass_scale)
		else $error("supply scale wrong with attenuator bypassed");

	property p_lock_hold;
		s_locked_write |=> $stable(cfg4_r);
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("locked config register changed on write");

	property p_open_write;
		s_open_write |=> cfg4_r == ($past(pwdata[7:0]) & CFG4_WR_MASK);
	endproperty
	a_open_write: assert property (p_open_write)
		else $error("unlocked config write not stored");

	property p_test3_read;
		s_read_test3 ##1 access |-> prdata == 32'h00000010;
	endproperty
	a_test3_read: assert property (p_test3_read)
		else $error("test register three reads wrong value");

	property p_cfg_reset;
		first_r |-> cfg4_r == CFG4_RST;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset)
		else $error("config register not zero after reset");

	property p_reserved_zero;
		s_read_cfg ##1 access |-> prdata[7:6] == 2'b00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved config bits read nonzero");

	property p_lock_sticky;
		lock_r |=> lock_r;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("config lock released without reset");

	property p_alarm_drive;
		(role_thermal_alarm_pin && !ot_off && thermal_limit_hit) |=>
			thermal_alarm_pin_oe;
	endproperty
	a_alarm_drive: assert property (p_alarm_drive)
		else $error("alarm pin not pulled on overtemp");
endmodule

// [tb/fan_monitor_config_four_regs_tb.sv]
// self-checking bench for the fan monitor config register slice
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module fan_monitor_config_four_regs_tb
	import fan_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [21:0] FS_N = 22'h2DC6C0;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, hit = 0, ovr, oe, pin_o, r1, r2, byp;
	logic [7:0] dm1 = 8'h11, dm2 = 8'h22, dm3 = 8'h33;
	logic [7:0] mx1 = 8'h44, mx2 = 8'h55, mx3 = 8'h66, d1, d2, d3, rv;
	logic tach, thermal_alarm_pin, alert, gpio, ev;
	logic [21:0] fs;
	logic pin_i = 1, v_r1, v_r2;
	int error_cnt = 0, checks = 0, cyc = 0;
	fan_monitor_config_four_regs #(.SUPPLY_FS_NORMAL_UV(FS_N)) dut (
		.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.thermal_limit_hit(hit), .fan_demand_1(dm1), .fan_demand_2(dm2),
		.fan_demand_3(dm3), .fan_max_speed_1(mx1), .fan_max_speed_2(mx2),
		.fan_max_speed_3(mx3), .fan_duty_1(d1), .fan_duty_2(d2),
		.fan_duty_3(d3), .fan_override_active(ovr),
		.fan_four_speed_input_en(tach), .thermal_alarm_role_en(thermal_alarm_pin),
		.smbalert_role_en(alert), .gpio_role_en(gpio),
		.thermal_alarm_pin_i(pin_i), .thermal_alarm_pin_o(pin_o),
		.thermal_alarm_pin_oe(oe), .thermal_alarm_pin_remote1_en(r1),
		.thermal_alarm_pin_remote2_en(r2), .supply_attenuator_bypass(byp),
		.supply_fullscale_uv(fs));
	// second copy built as the variant that honours the channel select
	fan_monitor_config_four_regs #(.HAS_CHAN_SEL(1'b1)) dut_var (
		.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(), .pready(), .pslverr(),
		.thermal_limit_hit(hit), .fan_demand_1(dm1), .fan_demand_2(dm2),
		.fan_demand_3(dm3), .fan_max_speed_1(mx1), .fan_max_speed_2(mx2),
		.fan_max_speed_3(mx3), .fan_duty_1(), .fan_duty_2(),
		.fan_duty_3(), .fan_override_active(),
		.fan_four_speed_input_en(), .thermal_alarm_role_en(),
		.smbalert_role_en(), .gpio_role_en(),
		.thermal_alarm_pin_i(pin_i), .thermal_alarm_pin_o(),
		.thermal_alarm_pin_oe(), .thermal_alarm_pin_remote1_en(v_r1),
		.thermal_alarm_pin_remote2_en(v_r2), .supply_attenuator_bypass(),
		.supply_fullscale_uv());
	initial begin
		forever #20 clk = ~clk;
	end
	// generous ceiling: the whole run needs under 120 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata[7:0];
		ev = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
		xfer(1'b0, idx, 8'h00);
		`CHK(rv, e)
	endtask
	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic t_reset();
		rd_chk(IDX_CFG4, 8'h00);
		rd_chk(IDX_TEST1, 8'h00);
		rd_chk(IDX_TEST2, 8'h00);
		rd_chk(IDX_TEST3, 8'h10);
		`CHK({gpio, alert, thermal_alarm_pin, tach}, 4'b0001)
		`CHK(fs, FS_N)
		`CHK({v_r1, v_r2}, 2'b01)
		$display("test reset done");
	endtask
	task automatic t_roles();
		for (int r = 0; r < 4; r++) begin
			// upper bits written high must not stick
			wr(IDX_CFG4, 8'hC0 | 8'(r));
			rd_chk(IDX_CFG4, 8'(r));
			@(negedge clk);
			`CHK({gpio, alert, thermal_alarm_pin, tach}, 4'b0001 << r)
			@(posedge clk);
		end
		$display("test roles done");
	endtask
	task automatic t_fans();
		wr(IDX_CFG4, 8'h00);
		settle();
		`CHK({d1, d2, d3}, {dm1, dm2, dm3})
		@(posedge clk) hit <= 1;
		settle();
		`CHK({d1, d2, d3}, {3{FULL_DUTY}})
		`CHK(ovr, 1'b1)
		@(posedge clk);
		wr(IDX_CFG4, 8'h08);
		settle();
		`CHK({d1, d2, d3}, {mx1, mx2, mx3})
		@(posedge clk) hit <= 0;
		$display("test fans done");
	endtask
	task automatic t_alarm();
		wr(IDX_CFG4, 8'h01);
		hit <= 1;
		settle();
		`CHK({oe, pin_o}, 2'b10)
		@(posedge clk);
		rd_chk(IDX_STATUS, 8'h03);
		@(posedge clk);
		wr(IDX_CFG4, 8'h05);
		// released pin is pulled low from outside and must be sensed
		pin_i <= 0;
		settle();
		`CHK(oe, 1'b0)
		@(posedge clk);
		rd_chk(IDX_STATUS, 8'h09);
		@(posedge clk) hit <= 0;
		pin_i <= 1;
		$display("test alarm done");
	endtask
	task automatic t_chan_supply();
		wr(IDX_CFG4, 8'h30);
		rd_chk(IDX_CFG4, 8'h30);
		@(negedge clk);
		`CHK({r1, r2}, 2'b01)
		`CHK({v_r1, v_r2}, 2'b11)
		`CHK({byp, fs}, {1'b1, 22'd2296500})
		@(posedge clk);
		$display("test channel and supply done");
	endtask
	task automatic t_lock();
		wr(IDX_TEST1, 8'hFF);
		wr(IDX_TEST3, 8'h00);
		rd_chk(IDX_TEST1, 8'h00);
		rd_chk(IDX_TEST3, 8'h10);
		wr(IDX_LOCK, 8'h01);
		rd_chk(IDX_STATUS, 8'h04);
		wr(IDX_CFG4, 8'h02);
		rd_chk(IDX_CFG4, 8'h30);
		rd_chk(8'hF0, 8'h00);
		`CHK(ev, 1'b1)
		$display("test lock done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		t_reset();
		t_roles();
		t_fans();
		t_alarm();
		t_chan_supply();
		t_lock();
		summarize();
	end
endmodule
